// ===== rtl/tvb_test_vector_tester.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
module tvb_test_vector_tester
    import tvb_pkg::*;
#(
    parameter int HALF      = HALF_CYCLES,
    parameter int ENTRY_MIN = ENTRY_MIN_SLOTS
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               srst,
    // Host register port
    input  wire logic [HOST_AW-1:0] hostAddr,
    input  wire logic [DATA_W-1:0]  hostWdata,
    input  wire logic               hostWr,
    input  wire logic               hostRd,
    output logic      [DATA_W-1:0]  hostRdata,
    // Device test pins
    output logic                    testRequestA,
    output logic                    testRequestB,
    input  wire logic               testAcknowledge,
    output logic                    externalTestClock,
    input  wire logic [DATA_W-1:0]  testPortBusIn,
    output logic      [DATA_W-1:0]  testPortBusOut,
    output logic                    testPortBusOe
);
    tvb_regs_s r;
    tvb_regs_s next_r;

    logic      running;
    logic      slotEnd;
    logic      forceTurn;
    tvb_kind_e announced;
    tvb_kind_e cmdKind;

    assign running   = (r.state == ST_ENTER) || (r.state == ST_SLOT) || (r.state == ST_EXIT);
    assign slotEnd   = running && r.pins.external_test_clock && (r.phase == 8'(HALF - 1));
    assign announced = tvb_kind_e'({r.pins.reqA, r.pins.reqB});
    assign cmdKind   = tvb_kind_e'(hostWdata[CMD_KIND_LSB +: 2]);
    // Turnaround slots must be announced with both lines high
    assign forceTurn = ((r.curKind == VK_READ) && (cmdKind != VK_READ))
                       || (r.turnLeft == 2'(TURN_SLOTS));

    always_comb begin
        next_r = r;
        // Two-flop synchronisers on pins from the device
        next_r.ackS1 = testAcknowledge;
        next_r.ackS2 = r.ackS1;
        next_r.busS1 = testPortBusIn;
        next_r.busS2 = r.busS1;

        // Free-running divider only while a slot is in flight; clock parks low
        if (running) begin
            if (r.phase == 8'(HALF - 1)) begin
                next_r.phase     = 8'h00;
                next_r.pins.external_test_clock = ~r.pins.external_test_clock;
            end else begin
                next_r.phase = r.phase + 8'h01;
            end
        end

        next_r.rdOut = '0;
        if (hostRd) begin
            case (hostAddr)
                OFF_DATA:   next_r.rdOut = r.dataReg;
                OFF_STATUS: begin
                    next_r.rdOut[ST_BUSY_BIT]      = (r.state != ST_IDLE) && (r.state != ST_READY);
                    next_r.rdOut[ST_TEST_BIT]      = r.testMode;
                    next_r.rdOut[ST_KIND_LSB +: 2] = r.curKind;
                    next_r.rdOut[ST_RVALID_BIT]    = r.rdValid;
                    next_r.rdOut[ST_TURN_LSB +: 2] = r.turnLeft;
                end
                OFF_RDATA: begin
                    next_r.rdOut   = r.rdData;
                    next_r.rdValid = 1'b0;
                end
                default:    next_r.rdOut = '0;
            endcase
        end
        if (hostWr && (hostAddr == OFF_DATA)) begin
            next_r.dataReg = hostWdata;
        end

        case (r.state)
            ST_IDLE: begin
                if (hostWr && (hostAddr == OFF_CMD) && hostWdata[CMD_GO_BIT]
                    && hostWdata[CMD_ENTER_BIT]) begin
                    next_r.state     = ST_ENTER;
                    next_r.pins.reqA = 1'b1;
                    next_r.pins.reqB = 1'b0;
                    next_r.entryCnt  = 16'h0000;
                    next_r.announce  = 1'b0;
                    next_r.phase     = 8'h00;
                end
            end
            ST_ENTER: begin
                if (slotEnd) begin
                    if (r.announce) begin
                        // The address vector has been announced; host supplies it
                        next_r.state    = ST_READY;
                        next_r.curKind  = VK_ADDR;
                        next_r.testMode = 1'b1;
                    end else begin
                        if (r.entryCnt != 16'hffff) begin
                            next_r.entryCnt = r.entryCnt + 16'h0001;
                        end
                        // Request a is held for a minimum span, not just until acknowledge
                        if (r.ackS2 && (r.entryCnt >= 16'(ENTRY_MIN - 1))) begin
                            next_r.announce  = 1'b1;
                            next_r.pins.reqB = 1'b1;
                        end
                    end
                end
            end
            ST_READY: begin
                if (hostWr && (hostAddr == OFF_CMD) && hostWdata[CMD_GO_BIT]) begin
                    next_r.state       = ST_SLOT;
                    next_r.phase       = 8'h00;
                    next_r.pins.busOut = r.dataReg;
                    // Never drive while the device may be driving
                    next_r.pins.busOe  = hostWdata[CMD_DRIVE_BIT] && (r.curKind != VK_READ)
                                         && (r.turnLeft == 2'b00);
                    if (forceTurn) begin
                        {next_r.pins.reqA, next_r.pins.reqB} = VK_ADDR;
                    end else begin
                        {next_r.pins.reqA, next_r.pins.reqB} = cmdKind;
                    end
                end
            end
            ST_SLOT: begin
                // Acknowledge low: lines and data stand, slot repeats
                if (slotEnd && r.ackS2) begin
                    next_r.curKind = announced;
                    if (!r.pins.busOe) begin
                        next_r.rdData  = r.busS2;
                        next_r.rdValid = 1'b1;
                    end
                    if ((r.curKind == VK_READ) && (announced != VK_READ)) begin
                        next_r.turnLeft = 2'(TURN_SLOTS);
                    end else if (r.turnLeft != 2'b00) begin
                        next_r.turnLeft = r.turnLeft - 2'b01;
                    end
                    // Release the port as soon as a read is announced, not at the next slot
                    if (announced == VK_READ) begin
                        next_r.pins.busOe = 1'b0;
                    end
                    if (announced == VK_EXIT) begin
                        next_r.state      = ST_EXIT;
                        next_r.pins.busOe = 1'b0;
                    end else begin
                        next_r.state = ST_READY;
                    end
                end
            end
            ST_EXIT: begin
                if (slotEnd && !r.ackS2) begin
                    next_r.state    = ST_IDLE;
                    next_r.testMode = 1'b0;
                    next_r.curKind  = VK_EXIT;
                    next_r.turnLeft = 2'b00;
                end
            end
            default: next_r.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            next_r_reset : r <= '{state: ST_IDLE, pins: '0, phase: 8'h00, curKind: VK_EXIT,
                dataReg: RESET_WORD, rdData: RESET_WORD, rdValid: 1'b0, turnLeft: 2'b00,
                entryCnt: 16'h0000, announce: 1'b0, testMode: 1'b0, rdOut: RESET_WORD,
                ackS1: 1'b0, ackS2: 1'b0, busS1: RESET_WORD, busS2: RESET_WORD};
        end else begin
            r <= next_r;
        end
    end

    assign hostRdata         = r.rdOut;
    assign testRequestA      = r.pins.reqA;
    assign testRequestB      = r.pins.reqB;
    assign externalTestClock = r.pins.external_test_clock;
    assign testPortBusOut    = r.pins.busOut;
    assign testPortBusOe     = r.pins.busOe;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    bus_no_clash_a : assert property (r.pins.busOe |-> r.curKind != VK_READ)
        else $error("tester drives the port in a read slot");
    turn_pair_a : assert property (r.turnLeft != 2'b00 |-> !r.pins.busOe)
        else $error("tester drives the port during turnaround");
    wait_hold_a : assert property ((r.state == ST_SLOT) && slotEnd && !r.ackS2
        |=> $stable(r.pins.busOut) && $stable(r.pins.reqA) && $stable(r.pins.reqB))
        else $error("vector changed while acknowledge was low");
    exit_lines_a : assert property (r.state == ST_EXIT |-> !r.pins.reqA && !r.pins.reqB)
        else $error("request lines not low during exit");
    enter_req_a : assert property ((r.state == ST_ENTER) && !r.announce
        |-> r.pins.reqA && !r.pins.reqB)
        else $error("entry request pattern wrong");
    read_catch_a : assert property ((r.state == ST_SLOT) && slotEnd && r.ackS2 && !r.pins.busOe
        |=> r.rdData == $past(r.busS2))
        else $error("read data not captured on acknowledge");
    entry_span_a : assert property ($rose(r.announce) |-> r.entryCnt >= 16'(ENTRY_MIN))
        else $error("request a held too briefly");
    external_test_clock_step_a : assert property ($changed(r.pins.external_test_clock) |-> $past(r.phase) == 8'(HALF - 1))
        else $error("test clock edge off the divider");
    addr_first_a : assert property ($rose(r.testMode) |-> r.pins.reqA && r.pins.reqB)
        else $error("first vector after entry is not an address");

    entry_done_c : cover property ($rose(r.testMode));
    write_slot_c : cover property ((r.state == ST_SLOT) && r.pins.busOe && slotEnd && r.ackS2);
    read_got_c   : cover property ($rose(r.rdValid));
    exit_done_c  : cover property ($fell(r.testMode));
endmodule

// ===== rtl/tvb_pkg.sv
package tvb_pkg;
    localparam int DATA_W = 32;
    localparam int HOST_AW = 4;

    // Host register offsets
    localparam logic [3:0] OFF_CMD    = 4'h0;
    localparam logic [3:0] OFF_DATA   = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_RDATA  = 4'hc;

    // Command register fields
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_KIND_LSB  = 1;
    localparam int CMD_DRIVE_BIT = 3;
    localparam int CMD_ENTER_BIT = 4;

    // Status register fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_TEST_BIT   = 1;
    localparam int ST_KIND_LSB   = 2;
    localparam int ST_RVALID_BIT = 4;
    localparam int ST_TURN_LSB   = 5;

    // Link timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int EXTERNAL_TEST_CLOCK_PERIOD_NS = 64;
    localparam int HALF_CYCLES    = EXTERNAL_TEST_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int ENTRY_MIN_SLOTS = 16;
    localparam int TURN_SLOTS     = 2;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

    // Request line pair {a, b} announcing the next vector
    typedef enum logic [1:0] {
        VK_EXIT  = 2'b00,
        VK_READ  = 2'b01,
        VK_WRITE = 2'b10,
        VK_ADDR  = 2'b11
    } tvb_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ENTER,
        ST_READY,
        ST_SLOT,
        ST_EXIT
    } tvb_state_e;

    typedef struct packed {
        logic              reqA;
        logic              reqB;
        logic              external_test_clock;
        logic [DATA_W-1:0] busOut;
        logic              busOe;
    } tvb_pins_s;

    typedef struct packed {
        tvb_state_e        state;
        tvb_pins_s         pins;
        logic [7:0]        phase;
        tvb_kind_e         curKind;
        logic [DATA_W-1:0] dataReg;
        logic [DATA_W-1:0] rdData;
        logic              rdValid;
        logic [1:0]        turnLeft;
        logic [15:0]       entryCnt;
        logic              announce;
        logic              testMode;
        logic [DATA_W-1:0] rdOut;
        logic              ackS1;
        logic              ackS2;
        logic [DATA_W-1:0] busS1;
        logic [DATA_W-1:0] busS2;
    } tvb_regs_s;
endpackage

// ===== verif/tvb_dev_model.sv
module tvb_dev_model
    import tvb_pkg::*;
#(
    parameter int GRANT = 4
) (
    // Link from the tester
    input  wire logic              external_test_clock,
    input  wire logic              srst,
    input  wire logic              reqA,
    input  wire logic              reqB,
    input  wire logic [DATA_W-1:0] busIn,
    // Bench control: stretch each write by one wait slot
    input  wire logic              slow,
    // Link back to the tester
    output logic                   ack,
    output logic      [DATA_W-1:0] busOut,
    output logic                   busOe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] addr;
    tvb_kind_e         cur;
    logic [1:0]        mode;
    logic [1:0]        size;
    logic [1:0]        turn;
    logic [3:0]        cnt;
    logic              inc;
    logic              run;
    logic              waited;

    // Only the low eight bits step, so a burst wraps inside its window
    function automatic logic [DATA_W-1:0] nxt(input logic [DATA_W-1:0] a);
        nxt = a;
        if (inc) nxt[7:0] = a[7:0] + (8'h1 << size);
    endfunction

    // The link clock parks between slots, so reset cannot wait for its edge
    always @(posedge external_test_clock or posedge srst) begin
        if (srst) begin
            mode <= 2'h0;
            ack <= 1'b0;
            busOe <= 1'b0;
            cnt <= 4'h0;
        end else if (mode == 2'h0) begin
            cnt <= reqA ? cnt + 4'h1 : 4'h0;
            if (reqA && cnt >= GRANT) begin
                ack <= 1'b1;
                mode <= 2'h1;
                inc <= 1'b0;
                size <= 2'h2;
            end
        end else if (mode == 2'h1) begin
            if ({reqA, reqB} == VK_ADDR) begin
                mode <= 2'h2;
                cur <= VK_ADDR;
                run <= 1'b0;
                turn <= 2'h0;
                waited <= 1'b0;
            end
        end else if (cur == VK_EXIT) begin
            ack <= 1'b0;
            mode <= 2'h0;
            cnt <= 4'h0;
        end else if (slow && cur == VK_WRITE && !waited) begin
            ack <= 1'b0;
            waited <= 1'b1;
        end else begin
            ack <= 1'b1;
            waited <= 1'b0;
            cur <= tvb_kind_e'({reqA, reqB});
            run <= 1'b0;
            case (cur)
                VK_WRITE: begin
                    mem[addr[5:2]] <= busIn;
                    addr <= nxt(addr);
                end
                VK_READ: begin
                    busOut <= mem[addr[5:2]];
                    busOe <= 1'b1;
                    turn <= 2'h2;
                    addr <= nxt(addr);
                end
                default: begin
                    if (turn == 2'h2) turn <= 2'h1;
                    else if (turn == 2'h1) begin
                        turn <= 2'h0;
                        busOe <= 1'b0;
                    end else if (run && {reqA, reqB} != VK_ADDR) begin
                        if (busIn[0]) begin
                            inc <= busIn[7];
                            size <= busIn[3:2];
                        end
                    end else begin
                        addr <= busIn;
                        run <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

// ===== verif/test_vector_bus_master_bench.sv
module test_vector_bus_master_bench
    import tvb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic               ref_clk = 1'b0;
    logic               srst;
    logic               hostWr = 1'b0;
    logic               hostRd = 1'b0;
    logic               slow = 1'b0;
    logic [HOST_AW-1:0] hostAddr = 4'h0;
    logic [DATA_W-1:0]  hostWdata = 32'h0;
    logic [DATA_W-1:0]  lastBus = 32'h0;
    logic [DATA_W-1:0]  lfsr = 32'h19;
    logic [DATA_W-1:0]  hostRdata, busOut, devBus, busIn, rd;
    logic [DATA_W-1:0]  w [4];
    logic               reqA, reqB, ack, external_test_clock, busOe, devOe;
    int                 errors = 0;
    int                 comparisons = 0;

    always #4 ref_clk = ~ref_clk;
    // A released bus shows the inverse of its last level, never a kind guess
    assign busIn = devOe ? devBus : busOe ? busOut : ~lastBus;
    always @(posedge ref_clk) begin
        if (devOe || busOe) lastBus <= busIn;
        if (devOe || busOe) check({31'h0, devOe & busOe}, 32'h0);
    end

    tvb_test_vector_tester #(.HALF(4), .ENTRY_MIN(2)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .hostAddr(hostAddr), .hostWdata(hostWdata),
        .hostWr(hostWr), .hostRd(hostRd), .hostRdata(hostRdata), .testRequestA(reqA),
        .testRequestB(reqB), .testAcknowledge(ack), .externalTestClock(external_test_clock),
        .testPortBusIn(busIn), .testPortBusOut(busOut), .testPortBusOe(busOe));
    tvb_dev_model i_dev (.external_test_clock(external_test_clock), .srst(srst), .reqA(reqA), .reqB(reqB), .busIn(busIn),
        .slow(slow), .ack(ack), .busOut(devBus), .busOe(devOe));

    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes drop for one edge between accesses so no signal is set twice per step
    task automatic hw(input logic [3:0] a, input logic [DATA_W-1:0] d);
        hostAddr <= a;
        hostWdata <= d;
        hostWr <= 1'b1;
        @(posedge ref_clk);
        hostWr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic hr(input logic [3:0] a, output logic [DATA_W-1:0] d);
        hostAddr <= a;
        hostRd <= 1'b1;
        @(posedge ref_clk);
        hostRd <= 1'b0;
        @(posedge ref_clk);
        d = hostRdata;
    endtask

    task automatic wait_st(input int b, input logic v);
        logic [DATA_W-1:0] s;
        for (int i = 0; i < 400; i++) begin
            hr(OFF_STATUS, s);
            if (s[b] === v) return;
        end
        errors++;
        give_verdict();
    endtask

    task automatic slot(input tvb_kind_e k, input logic drv, input logic [DATA_W-1:0] d);
        hw(OFF_DATA, d);
        hw(OFF_CMD, 32'h1 | (32'(k) << CMD_KIND_LSB) | (32'(drv) << CMD_DRIVE_BIT));
        wait_st(ST_BUSY_BIT, 1'b0);
    endtask

    task automatic rdat(input logic [DATA_W-1:0] exp);
        hr(OFF_RDATA, rd);
        check(rd, exp);
    endtask

    function automatic logic [DATA_W-1:0] nextRand(input logic [DATA_W-1:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    initial begin
        // Scheduled so the partner model sees a clean rising reset edge
        srst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check({27'h0, reqA, reqB, external_test_clock, busOe, ack}, 32'h0);
        hr(OFF_STATUS, rd);
        check(rd, 32'h0);
        hr(4'h2, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nextRand(lfsr);
            w[i] = lfsr;
        end
        hw(OFF_CMD, 32'h11);
        wait_st(ST_TEST_BIT, 1'b1);
        check({30'h0, reqA, reqB}, 32'h3);
        // No control vector yet: both writes land on one address
        slot(VK_WRITE, 1'b1, 32'h30);
        slot(VK_WRITE, 1'b1, w[0]);
        slot(VK_READ, 1'b1, w[1]);
        slot(VK_ADDR, 1'b0, 32'h0);
        slot(VK_ADDR, 1'b0, 32'h0);
        rdat(w[1]);
        slot(VK_ADDR, 1'b0, 32'h0);
        // Incrementing word burst, writes wait-stated by the device
        slow <= 1'b1;
        slot(VK_ADDR, 1'b1, 32'h40);
        slot(VK_WRITE, 1'b1, 32'h8b);
        for (int i = 0; i < 4; i++) slot(i == 3 ? VK_ADDR : VK_WRITE, 1'b1, w[i]);
        slow <= 1'b0;
        slot(VK_READ, 1'b1, 32'h40);
        for (int i = 0; i < 4; i++) begin
            slot(i == 3 ? VK_ADDR : VK_READ, 1'b0, 32'h0);
            rdat(w[i]);
        end
        slot(VK_ADDR, 1'b0, 32'h0);
        rdat(w[3]);
        slot(VK_ADDR, 1'b0, 32'h0);
        // Increment off, then an invalid control vector that would turn it on
        slot(VK_ADDR, 1'b1, 32'h50);
        slot(VK_WRITE, 1'b1, 32'h09);
        slot(VK_WRITE, 1'b1, w[0]);
        slot(VK_ADDR, 1'b1, w[1]);
        slot(VK_ADDR, 1'b1, 32'h50);
        slot(VK_READ, 1'b1, 32'h80);
        slot(VK_READ, 1'b0, 32'h0);
        slot(VK_ADDR, 1'b0, 32'h0);
        rdat(w[1]);
        slot(VK_ADDR, 1'b0, 32'h0);
        rdat(w[1]);
        slot(VK_WRITE, 1'b0, 32'h0);
        slot(VK_ADDR, 1'b1, w[2]);
        slot(VK_READ, 1'b1, 32'h50);
        slot(VK_ADDR, 1'b0, 32'h0);
        slot(VK_ADDR, 1'b0, 32'h0);
        rdat(w[2]);
        slot(VK_ADDR, 1'b0, 32'h0);
        // Exit after one address vector
        slot(VK_EXIT, 1'b1, 32'h0);
        wait_st(ST_TEST_BIT, 1'b0);
        check({29'h0, reqA, reqB, busOe}, 32'h0);
        give_verdict();
    end
endmodule
